// ===== rtl/dtx_pkg.sv
/*
  dtx_pkg: constants for the descriptor type decoder and exception vector unit.
  Assumes a single core clock domain; included by all dtx design files.
*/
package dtx_pkg;

  // ----------------------------------------------------------------
  // vector numbers
  // ----------------------------------------------------------------
  localparam logic [7:0] VEC_DIVIDE      = 8'h00;
  localparam logic [7:0] VEC_DEBUG       = 8'h01;
  localparam logic [7:0] VEC_NMI         = 8'h02;
  localparam logic [7:0] VEC_BREAKPOINT  = 8'h03;
  localparam logic [7:0] VEC_OVERFLOW    = 8'h04;
  localparam logic [7:0] VEC_BOUNDS      = 8'h05;
  localparam logic [7:0] VEC_INV_OPCODE  = 8'h06;
  localparam logic [7:0] VEC_DEV_NA      = 8'h07;
  localparam logic [7:0] VEC_DOUBLE      = 8'h08;
  localparam logic [7:0] VEC_RESERVED9   = 8'h09;
  localparam logic [7:0] VEC_INV_TASKSEG = 8'h0A;
  localparam logic [7:0] VEC_SEG_NP      = 8'h0B;
  localparam logic [7:0] VEC_STACK       = 8'h0C;
  localparam logic [7:0] VEC_GEN_PROT    = 8'h0D;
  localparam logic [7:0] VEC_PAGE        = 8'h0E;
  localparam logic [7:0] VEC_RESERVED15  = 8'h0F;
  localparam logic [7:0] VEC_FLOAT       = 8'h10;
  localparam logic [7:0] VEC_ALIGN       = 8'h11;

  // ----------------------------------------------------------------
  // fault sources, index order = priority (low index wins)
  // ----------------------------------------------------------------
  localparam int NUM_SRC   = 16;
  localparam int SRC_W     = 4;
  localparam int SRC_NMI   = 0;
  localparam int SRC_DBG   = 1;
  localparam int SRC_DIV   = 2;
  localparam int SRC_BRK   = 3;
  localparam int SRC_OVF   = 4;
  localparam int SRC_BND   = 5;
  localparam int SRC_INVOP = 6;
  localparam int SRC_DEVNA = 7;
  localparam int SRC_TASK  = 8;
  localparam int SRC_SEGNP = 9;
  localparam int SRC_STACK = 10;
  localparam int SRC_GP    = 11;
  localparam int SRC_PAGE  = 12;
  localparam int SRC_FLT   = 13;
  localparam int SRC_ALIGN = 14;
  localparam int SRC_DESC  = 15;

  // ----------------------------------------------------------------
  // descriptor type codes
  // ----------------------------------------------------------------
  localparam logic [3:0] TY_TSS16_AVAIL = 4'h1;
  localparam logic [3:0] TY_LDT         = 4'h2;
  localparam logic [3:0] TY_TSS16_BUSY  = 4'h3;
  localparam logic [3:0] TY_CALL16      = 4'h4;
  localparam logic [3:0] TY_TASK_GATE   = 4'h5;
  localparam logic [3:0] TY_INT16       = 4'h6;
  localparam logic [3:0] TY_TRAP16      = 4'h7;
  localparam logic [3:0] TY_TSS32_AVAIL = 4'h9;
  localparam logic [3:0] TY_TSS32_BUSY  = 4'hB;
  localparam logic [3:0] TY_CALL32      = 4'hC;
  localparam logic [3:0] TY_INT32       = 4'hE;
  localparam logic [3:0] TY_TRAP32      = 4'hF;
  localparam int TY_BIT_ACC  = 0;
  localparam int TY_BIT_RW   = 1;
  localparam int TY_BIT_DIR  = 2;
  localparam int TY_BIT_CODE = 3;

  // ----------------------------------------------------------------
  // wishbone register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int ADR_W = 4;
  localparam logic [3:0] ADR_STATUS = 4'h0;
  localparam logic [3:0] ADR_CLEAR  = 4'h4;
  localparam logic [3:0] ADR_ENABLE = 4'h8;
  localparam logic [3:0] ADR_VECTOR = 4'hC;
  localparam logic [15:0] ENABLE_RST = 16'h0000;

  typedef enum logic [1:0] {
    DTX_IDLE    = 2'b01,
    DTX_DELIVER = 2'b10
  } dtx_state_e;

endpackage : dtx_pkg

// ===== rtl/dtx_type_decode.sv
/*
  dtx_type_decode: purely combinational decode of a 4-bit descriptor type.
  Assumes type code and system flag are stable in the core clock domain.
*/
`timescale 1ns/1ps
module dtx_type_decode
  import dtx_pkg::*;
(
  // descriptor
  input  wire logic [3:0] type_i,
  input  wire logic       sys_i,
  // application class
  output logic            is_data_o,
  output logic            is_code_o,
  output logic            accessed_o,
  output logic            writable_o,
  output logic            expand_down_o,
  output logic            readable_o,
  output logic            conforming_o,
  // system class
  output logic            tss16_avail_o,
  output logic            tss16_busy_o,
  output logic            tss32_avail_o,
  output logic            tss32_busy_o,
  output logic            ldt_o,
  output logic            call_gate_o,
  output logic            task_gate_o,
  output logic            int_gate_o,
  output logic            trap_gate_o,
  output logic            gate32_o,
  output logic            reserved_o
);

  wire app = !sys_i;

  assign is_data_o     = app && !type_i[TY_BIT_CODE]; // see RL1
  assign is_code_o     = app && type_i[TY_BIT_CODE]; // see RL2
  assign accessed_o    = app && type_i[TY_BIT_ACC]; // see RL1
  assign writable_o    = is_data_o && type_i[TY_BIT_RW]; // see RL1
  assign expand_down_o = is_data_o && type_i[TY_BIT_DIR]; // see RL1
  assign readable_o    = is_data_o || (is_code_o && type_i[TY_BIT_RW]); // see RL2
  assign conforming_o  = is_code_o && type_i[TY_BIT_DIR]; // see RL2

  assign tss16_avail_o = sys_i && type_i == TY_TSS16_AVAIL; // see RL3
  assign ldt_o         = sys_i && type_i == TY_LDT; // see RL3
  assign tss16_busy_o  = sys_i && type_i == TY_TSS16_BUSY; // see RL3
  assign tss32_avail_o = sys_i && type_i == TY_TSS32_AVAIL; // see RL3
  assign tss32_busy_o  = sys_i && type_i == TY_TSS32_BUSY; // see RL3
  assign call_gate_o   = sys_i && (type_i == TY_CALL16 || type_i == TY_CALL32); // see RL4
  assign task_gate_o   = sys_i && type_i == TY_TASK_GATE;               // see RL4
  assign int_gate_o    = sys_i && (type_i == TY_INT16 || type_i == TY_INT32);   // see RL4
  assign trap_gate_o   = sys_i && (type_i == TY_TRAP16 || type_i == TY_TRAP32); // see RL4
  assign gate32_o      = call_gate_o | int_gate_o | trap_gate_o ? type_i[TY_BIT_CODE] : 1'b0;
  assign reserved_o    = sys_i && !(tss16_avail_o | ldt_o | tss16_busy_o | tss32_avail_o
                         | tss32_busy_o | call_gate_o | task_gate_o | int_gate_o
                         | trap_gate_o);                                // see RL16

endmodule : dtx_type_decode

// ===== rtl/dtx_vector_unit.sv
/*
  dtx_vector_unit: descriptor type decode plus fault-to-vector mapping
  with pending hold, double-fault escalation, and a wishbone status port.
  Assumes fault inputs are one-cycle pulses from core logic on mclk_i,
  and dispatch accepts a vector with vec_ack_i.
*/
// Added by the designer: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
// How it works
// RL1 - data types 0-7: accessed, writable, expand-down
// RL2 - code types 8-F: accessed, readable, conforming
// RL3 - system types decode task segments, local table
// RL4 - gate types decode call, task, interrupt, trap
// RL5 - divide by zero gives vector 0
// RL6 - vectors 1 to 7 for listed causes
// RL7 - fault during delivery gives double fault 8
// RL8 - vector 9 is never raised
// RL9 - invalid target task segment gives vector 10
// RL10 - segment load not present gives vector 11
// RL11 - stack limit or not present gives 12
// RL12 - protection and misc invalid give vector 13
// RL13 - page protection or missing page gives 14
// RL14 - float error gives 16, never 15
// RL15 - unaligned gives 17 only with both bits
// RL16 - reserved system types fault as protection
// RL17 - one vector at a time, lowest source index first
module dtx_vector_unit
  import dtx_pkg::*;
(
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        sys_rst_i,
  // descriptor under load
  input  wire logic [3:0]  desc_type_i,
  input  wire logic        desc_sys_i,
  input  wire logic        desc_load_i,
  output logic             desc_data_o,
  output logic             desc_code_o,
  output logic             desc_accessed_o,
  output logic             desc_writable_o,
  output logic             desc_expand_down_o,
  output logic             desc_readable_o,
  output logic             desc_conforming_o,
  output logic             desc_tss_avail_o,
  output logic             desc_tss_busy_o,
  output logic             desc_tss32_o,
  output logic             desc_local_descriptor_table_o,
  output logic             desc_call_gate_o,
  output logic             desc_task_gate_o,
  output logic             desc_int_gate_o,
  output logic             desc_trap_gate_o,
  output logic             desc_gate32_o,
  output logic             desc_invalid_o,
  // fault conditions
  input  wire logic        divide_zero_i,
  input  wire logic        debug_i,
  input  wire logic        nmi_i,
  input  wire logic        breakpoint_i,
  input  wire logic        overflow_i,
  input  wire logic        bounds_i,
  input  wire logic        invalid_opcode_i,
  input  wire logic        device_na_i,
  input  wire logic        task_seg_invalid_i,
  input  wire logic        seg_not_present_i,
  input  wire logic        stack_fault_i,
  input  wire logic        gen_prot_i,
  input  wire logic        page_fault_i,
  input  wire logic        float_error_i,
  input  wire logic        unaligned_i,
  input  wire logic        alignment_check_flag_i,
  input  wire logic        alignment_mask_bit_i,
  // dispatch
  output logic             vec_valid_o,
  output logic [7:0]       vec_num_o,
  input  wire logic        vec_ack_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // interrupt
  output logic             irq_o
);

  // ----------------------------------------------------------------
  // descriptor decode
  // ----------------------------------------------------------------
  logic t16a, t16b, t32a, t32b, rsv;

  dtx_type_decode u_dec (
    .type_i        (desc_type_i),
    .sys_i         (desc_sys_i),
    .is_data_o     (desc_data_o),
    .is_code_o     (desc_code_o),
    .accessed_o    (desc_accessed_o),
    .writable_o    (desc_writable_o),
    .expand_down_o (desc_expand_down_o),
    .readable_o    (desc_readable_o),
    .conforming_o  (desc_conforming_o),
    .tss16_avail_o (t16a),
    .tss16_busy_o  (t16b),
    .tss32_avail_o (t32a),
    .tss32_busy_o  (t32b),
    .ldt_o         (desc_local_descriptor_table_o),
    .call_gate_o   (desc_call_gate_o),
    .task_gate_o   (desc_task_gate_o),
    .int_gate_o    (desc_int_gate_o),
    .trap_gate_o   (desc_trap_gate_o),
    .gate32_o      (desc_gate32_o),
    .reserved_o    (rsv)
  );

  assign desc_tss_avail_o = t16a | t32a;
  assign desc_tss_busy_o  = t16b | t32b;
  assign desc_tss32_o     = t32a | t32b;
  assign desc_invalid_o   = rsv;

  // ----------------------------------------------------------------
  // fault sources
  // ----------------------------------------------------------------
  wire align_fault = unaligned_i && alignment_check_flag_i && alignment_mask_bit_i; // see RL15
  wire desc_fault  = desc_load_i && rsv;                                           // see RL16

  wire [NUM_SRC-1:0] raw_src;
  assign raw_src[SRC_NMI]   = nmi_i;
  assign raw_src[SRC_DBG]   = debug_i;
  assign raw_src[SRC_DIV]   = divide_zero_i;
  assign raw_src[SRC_BRK]   = breakpoint_i;
  assign raw_src[SRC_OVF]   = overflow_i;
  assign raw_src[SRC_BND]   = bounds_i;
  assign raw_src[SRC_INVOP] = invalid_opcode_i;
  assign raw_src[SRC_DEVNA] = device_na_i;
  assign raw_src[SRC_TASK]  = task_seg_invalid_i;
  assign raw_src[SRC_SEGNP] = seg_not_present_i;
  assign raw_src[SRC_STACK] = stack_fault_i;
  assign raw_src[SRC_GP]    = gen_prot_i;
  assign raw_src[SRC_PAGE]  = page_fault_i;
  assign raw_src[SRC_FLT]   = float_error_i;
  assign raw_src[SRC_ALIGN] = align_fault;
  assign raw_src[SRC_DESC]  = desc_fault;

  // ----------------------------------------------------------------
  // source to vector map
  // ----------------------------------------------------------------
  function automatic logic [7:0] src_vector(input logic [SRC_W-1:0] s);
    logic [7:0] v;
    case (s)
      4'h0: v = VEC_NMI; // see RL6
      4'h1: v = VEC_DEBUG; // see RL6
      4'h2: v = VEC_DIVIDE; // see RL5
      4'h3: v = VEC_BREAKPOINT; // see RL6
      4'h4: v = VEC_OVERFLOW; // see RL6
      4'h5: v = VEC_BOUNDS; // see RL6
      4'h6: v = VEC_INV_OPCODE; // see RL6
      4'h7: v = VEC_DEV_NA; // see RL6
      4'h8: v = VEC_INV_TASKSEG; // see RL9
      4'h9: v = VEC_SEG_NP; // see RL10
      4'hA: v = VEC_STACK; // see RL11
      4'hB: v = VEC_GEN_PROT; // see RL12
      4'hC: v = VEC_PAGE; // see RL13
      4'hD: v = VEC_FLOAT; // see RL14
      4'hE: v = VEC_ALIGN; // see RL15
      4'hF: v = VEC_GEN_PROT; // see RL16
      default: v = VEC_GEN_PROT;
    endcase
    // reserved 9 and 15 are unreachable by construction, see RL8
    return v;
  endfunction : src_vector

  // ----------------------------------------------------------------
  // pending hold and selection
  // ----------------------------------------------------------------
  dtx_state_e        state;
  dtx_state_e        next_state;
  logic [NUM_SRC-1:0] pending;
  logic [NUM_SRC-1:0] next_pending;
  logic [7:0]         cur_vec;
  logic [7:0]         next_cur_vec;
  logic               cur_double;

  wire [NUM_SRC-1:0] all_req = pending | raw_src;
  wire               any_req = |all_req;

  logic [SRC_W-1:0] pick;
  always_comb begin
    pick = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (all_req[i]) begin
        pick = SRC_W'(i);                                   // see RL17
      end
    end
  end

  wire [NUM_SRC-1:0] pick_mask = NUM_SRC'(1) << pick;
  wire               delivering = (state == DTX_DELIVER);
  wire               new_in_delivery = delivering && !vec_ack_i && |raw_src && !cur_double;

  always_comb begin
    next_state   = state;
    next_pending = pending;
    next_cur_vec = cur_vec;
    case (state)
      DTX_IDLE: begin
        if (any_req) begin
          next_state   = DTX_DELIVER;
          next_cur_vec = src_vector(pick);
          next_pending = all_req & ~pick_mask;              // see RL17
        end
      end
      DTX_DELIVER: begin
        if (vec_ack_i) begin
          next_state   = DTX_IDLE;
          next_pending = pending | raw_src;
        end else if (new_in_delivery) begin
          next_cur_vec = VEC_DOUBLE;                        // see RL7
        end else begin
          next_pending = pending | raw_src;
        end
      end
      default: begin
        next_state   = DTX_IDLE;
        next_pending = '0;
        next_cur_vec = VEC_GEN_PROT;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state      <= DTX_IDLE;
      pending    <= '0;
      cur_vec    <= VEC_DIVIDE;
      cur_double <= 1'b0;
    end else begin
      state      <= next_state;
      pending    <= next_pending;
      cur_vec    <= next_cur_vec;
      cur_double <= (next_state == DTX_DELIVER) && (next_cur_vec == VEC_DOUBLE);
    end
  end

  assign vec_valid_o = delivering;
  assign vec_num_o   = cur_vec;

  // ----------------------------------------------------------------
  // event status, enable and interrupt
  // ----------------------------------------------------------------
  logic [NUM_SRC-1:0] status;
  logic [NUM_SRC-1:0] enable;

  wire wb_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wb_wr   = wb_req && wb_we_i;
  wire hit_clr = wb_wr && (wb_adr_i == ADR_CLEAR);
  wire hit_en  = wb_wr && (wb_adr_i == ADR_ENABLE);

  wire [NUM_SRC-1:0] wr_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [NUM_SRC-1:0] clr_bits = hit_clr ? (wb_dat_i[NUM_SRC-1:0] & wr_mask) : '0;
  wire [NUM_SRC-1:0] next_status = (status & ~clr_bits) | raw_src;
  wire [NUM_SRC-1:0] next_enable = (enable & ~wr_mask) | (wb_dat_i[NUM_SRC-1:0] & wr_mask);

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      status <= '0;
      enable <= ENABLE_RST;
    end else begin
      status <= next_status;
      if (hit_en) begin
        enable <= next_enable;
      end
    end
  end

  assign irq_o = |(status & enable);

  // ----------------------------------------------------------------
  // wishbone read path, one wait-free ack cycle
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    case (wb_adr_i)
      ADR_STATUS: rd_mux = {16'h0000, status};
      ADR_ENABLE: rd_mux = {16'h0000, enable};
      ADR_VECTOR: rd_mux = {15'h0000, cur_double, 7'h00, delivering, cur_vec};
      default:    rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_mux : 32'h0000_0000;
    end
  end

endmodule : dtx_vector_unit

// ===== tb/dtx_core_model.sv
/*
  dtx_core_model: dispatch side of the core, accepting presented vectors.
  Assumes one clock and a synchronous active-high reset shared with the unit.
*/
`timescale 1ns/1ps
module dtx_core_model (
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic sys_rst_i,
  // dispatch
  input  wire logic hold_i,
  input  wire logic vec_valid_i,
  output logic      vec_ack_o
);
  int seed     = 42;
  int wait_cnt = 0;

  // accept after a random 0 to 3 cycle stall, never while held
  always @(posedge mclk_i) begin
    if (sys_rst_i || !vec_valid_i || vec_ack_o) begin
      vec_ack_o <= 1'b0;
      wait_cnt  <= $random(seed) & 3;
    end else if (wait_cnt == 0 && !hold_i) begin
      vec_ack_o <= 1'b1;
    end else if (wait_cnt > 0) begin
      wait_cnt <= wait_cnt - 1;
    end
  end
endmodule : dtx_core_model

// ===== tb/dtx_vector_unit_chk.sv
/*
  dtx_vector_unit_chk: port-level assertions for the vector unit.
  Assumes one clock and a synchronous active-high reset; bound below.
*/
`timescale 1ns/1ps
module dtx_vector_unit_chk
  import dtx_pkg::*;
(
  input wire logic       mclk_i,
  input wire logic       sys_rst_i,
  input wire logic [3:0] desc_type_i,
  input wire logic       desc_sys_i,
  input wire logic       desc_data_o,
  input wire logic       desc_invalid_o,
  input wire logic       divide_zero_i,
  input wire logic       debug_i,
  input wire logic       nmi_i,
  input wire logic       page_fault_i,
  input wire logic       unaligned_i,
  input wire logic       alignment_check_flag_i,
  input wire logic       alignment_mask_bit_i,
  input wire logic       vec_valid_o,
  input wire logic [7:0] vec_num_o,
  input wire logic       vec_ack_i,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  input wire logic       irq_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  wire qual   = alignment_check_flag_i & alignment_mask_bit_i;
  wire others = nmi_i | debug_i | divide_zero_i | page_fault_i;
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_reset_quiet: assert property (
    $past(sys_rst_i) |-> !vec_valid_o && !irq_o && !wb_ack_o) else $error("busy after reset");
  a_ack_timing: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o) else $error("bad ack");
  a_nmi_first: assert property (
    !vec_valid_o && nmi_i |=> vec_valid_o && vec_num_o == VEC_NMI) else $error("nmi vector");
  a_div_zero: assert property (
    !vec_valid_o && divide_zero_i && !nmi_i && !debug_i |=> vec_num_o == VEC_DIVIDE)
    else $error("divide vector");
  a_double_fault: assert property (
    vec_valid_o && !vec_ack_i && page_fault_i && vec_num_o != VEC_DOUBLE
    |=> vec_valid_o && vec_num_o == VEC_DOUBLE) else $error("no double fault");
  a_no_rsvd_vec: assert property (
    vec_valid_o |-> vec_num_o != VEC_RESERVED9 && vec_num_o != VEC_RESERVED15
    && vec_num_o <= VEC_ALIGN) else $error("reserved vector");
  a_align_off: assert property (
    !vec_valid_o && unaligned_i && !qual && !others |=> !vec_valid_o) else $error("align off");
  a_align_on: assert property (
    !vec_valid_o && unaligned_i && qual && !others |=> vec_num_o == VEC_ALIGN)
    else $error("align vector");
  a_valid_hold: assert property (
    vec_valid_o && !vec_ack_i |=> $stable(vec_valid_o)) else $error("vector dropped");
  a_valid_release: assert property (
    vec_valid_o && vec_ack_i |=> !vec_valid_o) else $error("vector kept");
  a_data_class: assert property (
    !desc_sys_i |-> desc_data_o == !desc_type_i[3]) else $error("data class");
  a_rsvd_type: assert property (
    desc_sys_i |-> desc_invalid_o == (desc_type_i inside {4'h0, 4'h8, 4'hA, 4'hD}))
    else $error("reserved type");
  c_double: cover property (vec_valid_o && vec_num_o == VEC_DOUBLE);
  c_irq: cover property (irq_o);
  c_align: cover property (vec_valid_o && vec_ack_i && vec_num_o == VEC_ALIGN);
endmodule : dtx_vector_unit_chk

bind dtx_vector_unit dtx_vector_unit_chk u_chk (
  .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .desc_type_i(desc_type_i),
  .desc_sys_i(desc_sys_i), .desc_data_o(desc_data_o), .desc_invalid_o(desc_invalid_o),
  .divide_zero_i(divide_zero_i), .debug_i(debug_i), .nmi_i(nmi_i),
  .page_fault_i(page_fault_i), .unaligned_i(unaligned_i),
  .alignment_check_flag_i(alignment_check_flag_i),
  .alignment_mask_bit_i(alignment_mask_bit_i), .vec_valid_o(vec_valid_o),
  .vec_num_o(vec_num_o), .vec_ack_i(vec_ack_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .irq_o(irq_o));

// ===== tb/test_dtx_vector_unit.sv
/*
  test_dtx_vector_unit: self-checking bench for the vector unit.
  Assumes dtx_core_model answers dispatch and the checker is bound.
*/
`timescale 1ns/1ps
module test_dtx_vector_unit;
  import dtx_pkg::*;
  logic        clk, rst, hold, ld, dsys, cyc, we;
  logic [3:0]  dtyp, adr, sel;
  logic [14:0] flt;
  logic [1:0]  acm;
  logic [31:0] wdat, rnd;
  wire  [31:0] rdat;
  wire  [16:0] dec;
  wire  [7:0]  vnum;
  wire         vval, vack, wack, irq;
  logic [7:0]  vt [15];
  logic [3:0]  rt [5];
  logic [31:0] vq [$];
  logic [31:0] rq [$];
  int          errors, cmp_count, seed, i;

  dtx_vector_unit dut (
    .mclk_i(clk), .sys_rst_i(rst), .desc_type_i(dtyp), .desc_sys_i(dsys), .desc_load_i(ld),
    .desc_data_o(dec[16]), .desc_code_o(dec[15]), .desc_accessed_o(dec[14]),
    .desc_writable_o(dec[13]), .desc_expand_down_o(dec[12]), .desc_readable_o(dec[11]),
    .desc_conforming_o(dec[10]), .desc_tss_avail_o(dec[9]), .desc_tss_busy_o(dec[8]),
    .desc_tss32_o(dec[7]), .desc_local_descriptor_table_o(dec[6]),
    .desc_call_gate_o(dec[5]), .desc_task_gate_o(dec[4]), .desc_int_gate_o(dec[3]),
    .desc_trap_gate_o(dec[2]), .desc_gate32_o(dec[1]), .desc_invalid_o(dec[0]),
    .divide_zero_i(flt[0]), .debug_i(flt[1]), .nmi_i(flt[2]), .breakpoint_i(flt[3]),
    .overflow_i(flt[4]), .bounds_i(flt[5]), .invalid_opcode_i(flt[6]),
    .device_na_i(flt[7]), .task_seg_invalid_i(flt[8]), .seg_not_present_i(flt[9]),
    .stack_fault_i(flt[10]), .gen_prot_i(flt[11]), .page_fault_i(flt[12]),
    .float_error_i(flt[13]), .unaligned_i(flt[14]), .alignment_check_flag_i(acm[1]),
    .alignment_mask_bit_i(acm[0]), .vec_valid_o(vval), .vec_num_o(vnum), .vec_ack_i(vack),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(wack), .irq_o(irq));

  dtx_core_model core (.mclk_i(clk), .sys_rst_i(rst), .hold_i(hold),
    .vec_valid_i(vval), .vec_ack_o(vack));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // checking
  // ----------------------------------------------------------------
  task check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task print_verdict;
    if (errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict

  always @(posedge clk) begin
    if (vval === 1'b1 && vack === 1'b1) begin
      check({24'h0, vnum}, vq.size() ? vq.pop_front() : 32'hDEAD);
    end
    if (wack === 1'b1 && we === 1'b0) begin
      check(rdat, rq.size() ? rq.pop_front() : 32'hDEAD);
    end
  end

  function automatic logic [31:0] dec_exp(input logic [4:0] c);
    logic [3:0] t;
    t = c[3:0];
    if (!c[4]) begin
      return {15'h0, !t[3], t[3], t[0], !t[3] & t[1], !t[3] & t[2], !t[3] | t[1],
              t[3] & t[2], 10'h0};
    end
    return {22'h0, t == 4'h1 || t == 4'h9, t == 4'h3 || t == 4'hB, t == 4'h9 || t == 4'hB,
            t == 4'h2, t == 4'h4 || t == 4'hC, t == 4'h5, t == 4'h6 || t == 4'hE,
            t == 4'h7 || t == 4'hF, t == 4'hC || t == 4'hE || t == 4'hF,
            t == 4'h0 || t == 4'h8 || t == 4'hA || t == 4'hD};
  endfunction : dec_exp

  // ----------------------------------------------------------------
  // drivers
  // ----------------------------------------------------------------
  task drain;
    int n;
    n = 0;
    while ((vq.size() > 0 || vval !== 1'b0) && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n >= 50) begin
      errors++;
      print_verdict;
    end
    repeat (2) @(posedge clk);
  endtask : drain

  task fire(input logic [14:0] m, input logic [7:0] e);
    vq.push_back({24'h0, e});
    @(posedge clk);
    flt <= m;
    @(posedge clk);
    flt <= '0;
    drain;
  endtask : fire

  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wack !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      print_verdict;
    end
    cyc <= 1'b0;
  endtask : wb

  task rd(input logic [3:0] a, input logic [31:0] e);
    rq.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask : rd

  task irq_is(input logic e);
    @(negedge clk);
    check({31'h0, irq}, {31'h0, e});
  endtask : irq_is

  initial begin
    {rst, hold, ld, dsys, cyc, we, flt, dtyp, adr, wdat} = '0;
    rst = 1'b1;
    sel = 4'hF;
    acm = 2'b11;
    {errors, cmp_count} = '0;
    seed = 42;
    vt = '{VEC_DIVIDE, VEC_DEBUG, VEC_NMI, VEC_BREAKPOINT, VEC_OVERFLOW, VEC_BOUNDS,
           VEC_INV_OPCODE, VEC_DEV_NA, VEC_INV_TASKSEG, VEC_SEG_NP, VEC_STACK,
           VEC_GEN_PROT, VEC_PAGE, VEC_FLOAT, VEC_ALIGN};
    rt = '{4'h0, 4'h8, 4'hA, 4'hD, 4'h2};
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 32; i++) begin
      @(posedge clk);
      {dsys, dtyp} <= i[4:0];
      @(negedge clk);
      check({15'h0, dec & (i[4] ? 17'h003FF : 17'h1FC00)}, dec_exp(i[4:0]));
    end
    for (i = 0; i < 15; i++) begin
      fire(15'h1 << i, vt[i]);
    end
    for (i = 0; i < 3; i++) begin
      @(posedge clk);
      acm <= i[1:0];
      flt <= 15'h4000;
      @(posedge clk);
      flt <= '0;
      repeat (3) @(posedge clk);
      check({31'h0, vval}, 32'h0);
    end
    acm <= 2'b11;
    vq.push_back({24'h0, VEC_NMI});
    fire(15'h1004, VEC_PAGE);
    for (i = 0; i < 5; i++) begin
      if (i < 4) vq.push_back({24'h0, VEC_GEN_PROT});
      @(posedge clk);
      dsys <= 1'b1;
      dtyp <= rt[i];
      ld   <= 1'b1;
      @(posedge clk);
      ld <= 1'b0;
      drain;
    end
    // sticky status, enable, clear, unmapped and masking
    rd(ADR_STATUS, 32'h0000FFFF);
    rnd = $random(seed) | 32'h1;
    wb(1'b1, ADR_ENABLE, rnd);
    rd(ADR_ENABLE, {16'h0, rnd[15:0]});
    irq_is(1'b1);
    wb(1'b1, ADR_STATUS, 32'h0);
    wb(1'b1, ADR_CLEAR, 32'hFFFF);
    rd(ADR_STATUS, 32'h0);
    irq_is(1'b0);
    rd(4'h2, 32'h0);
    wb(1'b1, ADR_ENABLE, 32'h1000);
    fire(15'h1000, VEC_PAGE);
    irq_is(1'b1);
    wb(1'b1, ADR_ENABLE, 32'h0);
    irq_is(1'b0);
    wb(1'b1, ADR_ENABLE, 32'h1000);
    irq_is(1'b1);
    wb(1'b1, ADR_CLEAR, 32'h1000);
    irq_is(1'b0);
    // fault while the dispatch stalls escalates
    @(posedge clk);
    hold <= 1'b1;
    flt  <= 15'h0800;
    @(posedge clk);
    flt <= '0;
    @(posedge clk);
    flt <= 15'h1000;
    @(posedge clk);
    flt <= '0;
    @(negedge clk);
    check({24'h0, vnum}, {24'h0, VEC_DOUBLE});
    @(posedge clk);
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst  <= 1'b0;
    hold <= 1'b0;
    rd(ADR_STATUS, 32'h0);
    rd(ADR_ENABLE, 32'h0);
    @(posedge clk);
    print_verdict;
  end
endmodule : test_dtx_vector_unit
